// file: shared/port_phy_map.vh
/*
 * Address map, field positions and reset values of the port PHY
 * control and status register bank.
 * Assumes a 32-bit AHB-Lite register bus with one register per word.
 */
`ifndef PORT_PHY_MAP_VH
`define PORT_PHY_MAP_VH

// Printed register indexes; byte address is four times the index
`define IDX_CABLE_DIAG_SPECIAL_CTRL 12'h07C
`define IDX_PORT_PHY_CONTROL        12'h07E
`define IDX_PORT_PHY_STATUS         12'h080
// Standard management register aliases, byte addresses
`define ADDR_PHY_BASIC_CONTROL      12'h240
`define ADDR_PHY_ADVERTISEMENT      12'h244
`define ADDR_PHY_SPECIAL_CONTROL    12'h248
`define ADDR_WIDTH                  12

// Diagnostic register fields
`define DIAG_SHORT_BIT       15
`define DIAG_OUTCOME_HI      14
`define DIAG_OUTCOME_LO      13
`define DIAG_START_BIT       12
`define DIAG_FORCE_LINK_BIT  11
`define DIAG_RES10_BIT       10
`define DIAG_NEAR_LB_BIT     9
`define DIAG_COUNT_HI        8
`define DIAG_RES10_RESET     1'h1

// Port control fields
`define CTRL_RES15_BIT       15
`define CTRL_TX_DIS_BIT      14
`define CTRL_AN_RESTART_BIT  13
`define CTRL_RES12_BIT       12
`define CTRL_PWR_DOWN_BIT    11
`define CTRL_MDIX_DIS_BIT    10
`define CTRL_FORCE_MDIX_BIT  9
`define CTRL_FAR_LB_BIT      8
`define CTRL_AN_EN_BIT       7
`define CTRL_SPEED_BIT       6
`define CTRL_DUPLEX_BIT      5
`define CTRL_ADV_HI          4
`define CTRL_AN_EN_RESET     1'h1
`define CTRL_SPEED_RESET     1'h1
`define CTRL_DUPLEX_RESET    1'h1
`define CTRL_ADV_RESET       5'h1F

// Port status fields
`define STAT_XOVER_SEL_BIT   15
`define STAT_POLARITY_BIT    13
`define STAT_TX_FC_BIT       12
`define STAT_RX_FC_BIT       11
`define STAT_XOVER_RESET     1'h1

// Basic control alias fields
`define BASIC_FAR_LB_BIT     14
`define BASIC_SPEED_BIT      13
`define BASIC_AN_EN_BIT      12
`define BASIC_PWR_DOWN_BIT   11
`define BASIC_AN_RESTART_BIT 9
`define BASIC_DUPLEX_BIT     8
`define BASIC_XOVER_SEL_BIT  5
`define BASIC_FORCE_MDIX_BIT 4
`define BASIC_MDIX_DIS_BIT   3
`define BASIC_RES_BIT        2
`define BASIC_TX_DIS_BIT     1

// Advertisement alias fields
`define ADV_PAUSE_BIT        10
`define ADV_100F_BIT         8
`define ADV_LO_BIT           5

// Special control alias fields
`define SPEC_POLARITY_BIT    5
`define SPEC_FORCE_LINK_BIT  3
`define SPEC_NEAR_LB_BIT     1

`endif

// file: design/port_phy_control_status_regs.v
/*
 * Control and status registers of the first switch port's PHY,
 * reached over AHB-Lite, with aliases in the standard management map.
 * Assumes the PHY core runs on hclk, so its status inputs need no
 * synchroniser, and that it pulses cable_test_done once per test.
 */
// The AHB-Lite register port was decided locally.
// Summary of operation
// - Short under ten metres flagged, bit 15
// - Cable test outcome in bits 14-13
// - Bit 12 starts test, clears when done
// - Fault distance count in bits 8-0
// - Bit 11 forces link pass
// - Bit 9 loops receive to transmit
// - Control bit 14 disables transmitter
// - Control bit 13 restarts negotiation, self-clears
// - Bit 11 powers down, registers kept
// - Bit 10 disables crossover, bit 9 forces
// - Bit 8 far-end loopback via port two
// - Bit 7 enables negotiation, else forced
// - Bit 6 selects 100 or 10 forced
// - Bit 5 selects duplex when forced/failed
// - Bits 4-0 advertise capabilities, reset ones
// - Status bit 15 selects crossover algorithm
// - Status bit 13 shows reversed polarity
// - Bits 12, 11 show flow control active
`timescale 1ns/10ps
`include "port_phy_map.vh"

module port_phy_control_status_regs (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Cable test handshake with the PHY
    output reg         cable_test_start,
    input  wire        cable_test_done,
    input  wire        near_short_in,
    input  wire [1:0]  cable_test_outcome_in,
    input  wire [8:0]  fault_distance_in,
    // PHY status
    input  wire        polarity_reversed,
    input  wire        tx_flow_ctrl_active,
    input  wire        rx_flow_ctrl_active,
    // PHY controls
    output reg         force_link_pass,
    output reg         near_loopback,
    output reg         tx_disable,
    output reg         an_restart,
    output reg         power_down,
    output reg         auto_mdix_disable,
    output reg         force_mdix,
    output reg         far_loopback,
    output reg         an_enable,
    output reg         force_speed_100,
    output reg         force_full_duplex,
    output reg  [4:0]  advertise,
    output reg         crossover_algorithm_select
);

    // Storage kept apart from the ports so reads see one copy
    reg        near_short_flag_q;
    reg [1:0]  cable_test_outcome_q;
    reg [8:0]  fault_distance_count_q;
    reg        diag_res10_q;
    reg        ctrl_res15_q;
    reg        ctrl_res12_q;

    // Bus pipeline
    reg                    wr_pend_q;
    reg                    rd_pend_q;
    reg [`ADDR_WIDTH-1:0]  addr_q;
    reg [15:0]             rd_mux;
    reg [15:0]             wd;
    reg                    sel_diag;
    reg                    sel_ctrl;
    reg                    sel_stat;
    reg                    sel_basic;
    reg                    sel_adv;
    reg                    sel_spec;

    wire accept = hsel & htrans[1] & hready;

    always @* begin
        wd        = hwdata[15:0];
        sel_diag  = addr_q == (`IDX_CABLE_DIAG_SPECIAL_CTRL << 2);
        sel_ctrl  = addr_q == (`IDX_PORT_PHY_CONTROL << 2);
        sel_stat  = addr_q == (`IDX_PORT_PHY_STATUS << 2);
        sel_basic = addr_q == `ADDR_PHY_BASIC_CONTROL;
        sel_adv   = addr_q == `ADDR_PHY_ADVERTISEMENT;
        sel_spec  = addr_q == `ADDR_PHY_SPECIAL_CONTROL;
    end

    // Read view of every register; unused bits read zero
    always @* begin
        rd_mux = 16'h0000;
        if (sel_diag) begin
            rd_mux[`DIAG_SHORT_BIT] = near_short_flag_q;
            rd_mux[`DIAG_OUTCOME_HI:`DIAG_OUTCOME_LO] =
                cable_test_outcome_q;
            rd_mux[`DIAG_START_BIT]      = cable_test_start;
            rd_mux[`DIAG_FORCE_LINK_BIT] = force_link_pass;
            rd_mux[`DIAG_RES10_BIT]      = diag_res10_q;
            rd_mux[`DIAG_NEAR_LB_BIT]    = near_loopback;
            rd_mux[`DIAG_COUNT_HI:0]     = fault_distance_count_q;
        end else if (sel_ctrl) begin
            rd_mux[`CTRL_RES15_BIT]      = ctrl_res15_q;
            rd_mux[`CTRL_TX_DIS_BIT]     = tx_disable;
            rd_mux[`CTRL_AN_RESTART_BIT] = an_restart;
            rd_mux[`CTRL_RES12_BIT]      = ctrl_res12_q;
            rd_mux[`CTRL_PWR_DOWN_BIT]   = power_down;
            rd_mux[`CTRL_MDIX_DIS_BIT]   = auto_mdix_disable;
            rd_mux[`CTRL_FORCE_MDIX_BIT] = force_mdix;
            rd_mux[`CTRL_FAR_LB_BIT]     = far_loopback;
            rd_mux[`CTRL_AN_EN_BIT]      = an_enable;
            rd_mux[`CTRL_SPEED_BIT]      = force_speed_100;
            rd_mux[`CTRL_DUPLEX_BIT]     = force_full_duplex;
            rd_mux[`CTRL_ADV_HI:0]       = advertise;
        end else if (sel_stat) begin
            rd_mux[`STAT_XOVER_SEL_BIT]  = crossover_algorithm_select;
            rd_mux[`STAT_POLARITY_BIT]   = polarity_reversed;
            rd_mux[`STAT_TX_FC_BIT]      = tx_flow_ctrl_active;
            rd_mux[`STAT_RX_FC_BIT]      = rx_flow_ctrl_active;
        end else if (sel_basic) begin
            // Port control view flops except reserved bit 15 and advertise, plus the status crossover select
            rd_mux[`BASIC_FAR_LB_BIT]     = far_loopback;
            rd_mux[`BASIC_SPEED_BIT]      = force_speed_100;
            rd_mux[`BASIC_AN_EN_BIT]      = an_enable;
            rd_mux[`BASIC_PWR_DOWN_BIT]   = power_down;
            rd_mux[`BASIC_AN_RESTART_BIT] = an_restart;
            rd_mux[`BASIC_DUPLEX_BIT]     = force_full_duplex;
            rd_mux[`BASIC_XOVER_SEL_BIT]  = crossover_algorithm_select;
            rd_mux[`BASIC_FORCE_MDIX_BIT] = force_mdix;
            rd_mux[`BASIC_MDIX_DIS_BIT]   = auto_mdix_disable;
            rd_mux[`BASIC_RES_BIT]        = ctrl_res12_q;
            rd_mux[`BASIC_TX_DIS_BIT]     = tx_disable;
        end else if (sel_adv) begin
            rd_mux[`ADV_PAUSE_BIT]           = advertise[4];
            rd_mux[`ADV_100F_BIT:`ADV_LO_BIT] = advertise[3:0];
        end else if (sel_spec) begin
            rd_mux[`SPEC_POLARITY_BIT]   = polarity_reversed;
            rd_mux[`SPEC_FORCE_LINK_BIT] = force_link_pass;
            rd_mux[`SPEC_NEAR_LB_BIT]    = near_loopback;
        end
    end

    // Bus handshake: writes in zero waits, reads take one wait state
    // so hrdata can leave a flop and still see a write just before it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= {`ADDR_WIDTH{1'b0}};
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hresp     <= 1'b0;
            if (rd_pend_q) begin
                hrdata    <= {16'h0000, rd_mux};
                hreadyout <= 1'b1;
            end else if (accept) begin
                // Addresses beyond the map decode to nothing
                addr_q    <= (haddr[31:`ADDR_WIDTH] == 0) ?
                             haddr[`ADDR_WIDTH-1:0] :
                             {`ADDR_WIDTH{1'b1}};
                wr_pend_q <= hwrite;
                rd_pend_q <= ~hwrite;
                hreadyout <= hwrite;
            end
        end
    end

    // Write strobes, live during the write data phase
    wire wr_diag  = wr_pend_q & sel_diag;
    wire wr_ctrl  = wr_pend_q & sel_ctrl;
    wire wr_stat  = wr_pend_q & sel_stat;
    wire wr_basic = wr_pend_q & sel_basic;
    wire wr_adv   = wr_pend_q & sel_adv;
    wire wr_spec  = wr_pend_q & sel_spec;
    wire test_end = cable_test_start & cable_test_done;

    // Results land with done so they are valid when start drops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            near_short_flag_q      <= 1'b0;
            cable_test_outcome_q   <= 2'h0;
            fault_distance_count_q <= 9'h000;
        end else if (test_end) begin
            near_short_flag_q      <= near_short_in;
            cable_test_outcome_q   <= cable_test_outcome_in;
            fault_distance_count_q <= fault_distance_in;
        end
    end

    // A new start beats a done in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cable_test_start <= 1'b0;
        else if (wr_diag && wd[`DIAG_START_BIT])
            cable_test_start <= 1'b1;
        else if (test_end)
            cable_test_start <= 1'b0;
    end

    // One flop per aliased bit, written from either view
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            force_link_pass <= 1'b0;
        else if (wr_diag)
            force_link_pass <= wd[`DIAG_FORCE_LINK_BIT];
        else if (wr_spec)
            force_link_pass <= wd[`SPEC_FORCE_LINK_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            diag_res10_q <= `DIAG_RES10_RESET;
        else if (wr_diag)
            diag_res10_q <= wd[`DIAG_RES10_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            near_loopback <= 1'b0;
        else if (wr_diag)
            near_loopback <= wd[`DIAG_NEAR_LB_BIT];
        else if (wr_spec)
            near_loopback <= wd[`SPEC_NEAR_LB_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ctrl_res15_q <= 1'b0;
        else if (wr_ctrl)
            ctrl_res15_q <= wd[`CTRL_RES15_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            tx_disable <= 1'b0;
        else if (wr_ctrl)
            tx_disable <= wd[`CTRL_TX_DIS_BIT];
        else if (wr_basic)
            tx_disable <= wd[`BASIC_TX_DIS_BIT];
    end

    // One-cycle restart pulse; only a read issued in the write's data phase sees it as one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            an_restart <= 1'b0;
        else if (wr_ctrl)
            an_restart <= wd[`CTRL_AN_RESTART_BIT];
        else if (wr_basic)
            an_restart <= wd[`BASIC_AN_RESTART_BIT];
        else
            an_restart <= 1'b0;
    end

    // Reserved, but reads back what was written
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ctrl_res12_q <= 1'b0;
        else if (wr_ctrl)
            ctrl_res12_q <= wd[`CTRL_RES12_BIT];
        else if (wr_basic)
            ctrl_res12_q <= wd[`BASIC_RES_BIT];
    end

    // Settings survive power down; only reset clears them
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            power_down <= 1'b0;
        else if (wr_ctrl)
            power_down <= wd[`CTRL_PWR_DOWN_BIT];
        else if (wr_basic)
            power_down <= wd[`BASIC_PWR_DOWN_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            auto_mdix_disable <= 1'b0;
        else if (wr_ctrl)
            auto_mdix_disable <= wd[`CTRL_MDIX_DIS_BIT];
        else if (wr_basic)
            auto_mdix_disable <= wd[`BASIC_MDIX_DIS_BIT];
    end

    // Only acts while automatic crossover is off
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            force_mdix <= 1'b0;
        else if (wr_ctrl)
            force_mdix <= wd[`CTRL_FORCE_MDIX_BIT];
        else if (wr_basic)
            force_mdix <= wd[`BASIC_FORCE_MDIX_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            far_loopback <= 1'b0;
        else if (wr_ctrl)
            far_loopback <= wd[`CTRL_FAR_LB_BIT];
        else if (wr_basic)
            far_loopback <= wd[`BASIC_FAR_LB_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            an_enable <= `CTRL_AN_EN_RESET;
        else if (wr_ctrl)
            an_enable <= wd[`CTRL_AN_EN_BIT];
        else if (wr_basic)
            an_enable <= wd[`BASIC_AN_EN_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            force_speed_100 <= `CTRL_SPEED_RESET;
        else if (wr_ctrl)
            force_speed_100 <= wd[`CTRL_SPEED_BIT];
        else if (wr_basic)
            force_speed_100 <= wd[`BASIC_SPEED_BIT];
    end

    // Also the fallback when negotiation fails
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            force_full_duplex <= `CTRL_DUPLEX_RESET;
        else if (wr_ctrl)
            force_full_duplex <= wd[`CTRL_DUPLEX_BIT];
        else if (wr_basic)
            force_full_duplex <= wd[`BASIC_DUPLEX_BIT];
    end

    // Pause ability on top, then the four speed abilities
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            advertise <= `CTRL_ADV_RESET;
        else if (wr_ctrl)
            advertise <= wd[`CTRL_ADV_HI:0];
        else if (wr_adv)
            advertise <= {wd[`ADV_PAUSE_BIT],
                          wd[`ADV_100F_BIT:`ADV_LO_BIT]};
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            crossover_algorithm_select <= `STAT_XOVER_RESET;
        else if (wr_stat)
            crossover_algorithm_select <= wd[`STAT_XOVER_SEL_BIT];
        else if (wr_basic)
            crossover_algorithm_select <= wd[`BASIC_XOVER_SEL_BIT];
    end

    // hsize is accepted as a whole-word access whatever its value
    wire unused_size = |hsize;

endmodule

// file: sim/port_phy_regs_chk.sv
/* Assertions on the ports of the port PHY register bank.
   Assumes hready is the bank's own hreadyout. */
`timescale 1ns/10ps
`include "port_phy_map.vh"
module port_phy_regs_chk (
    // Clock and reset
    input wire        hclk,
    input wire        hresetn,
    // Bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // PHY side
    input wire        cable_test_start,
    input wire        cable_test_done,
    input wire        an_restart,
    input wire        tx_disable,
    input wire        power_down
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        wr_q;
    logic [31:0] wa_q;
    // Marks the data phase of a write, updates land at its end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 32'h0;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            wa_q <= haddr;
        end
    end
    sequence s_rd_take;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr_take;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_wr_diag;
        wr_q && wa_q == `IDX_CABLE_DIAG_SPECIAL_CTRL * 4;
    endsequence
    sequence s_wr_ctrl;
        wr_q && wa_q == `IDX_PORT_PHY_CONTROL * 4;
    endsequence
    sequence s_wr_basic;
        wr_q && wa_q == `ADDR_PHY_BASIC_CONTROL;
    endsequence
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_rd_wait;
        s_rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_wr_nowait;
        s_wr_take |=> hreadyout;
    endproperty
    property p_upper_zero;
        hrdata[31:16] == 16'h0000;
    endproperty
    property p_start_set;
        s_wr_diag ##0 hwdata[12] |=> cable_test_start;
    endproperty
    property p_start_clr;
        $fell(cable_test_start) |-> $past(cable_test_done);
    endproperty
    property p_restart;
        s_wr_ctrl ##0 hwdata[13] |=> an_restart ##1 !an_restart;
    endproperty
    property p_tx_dis;
        s_wr_ctrl |=> tx_disable == $past(hwdata[14]);
    endproperty
    property p_alias_pd;
        s_wr_basic |=> power_down == $past(hwdata[11]);
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    a_start_set: assert property (p_start_set)
        else $error("test start not raised");
    a_start_clr: assert property (p_start_clr)
        else $error("test start fell early");
    a_restart: assert property (p_restart)
        else $error("restart pulse wrong");
    a_tx_dis: assert property (p_tx_dis)
        else $error("transmit disable wrong");
    a_alias_pd: assert property (p_alias_pd)
        else $error("alias power down wrong");
endmodule

// file: sim/cable_phy_model.sv
/* Behavioural PHY cable tester answering the bank's test start.
   Assumes start is a level held until done is seen. */
`timescale 1ns/10ps
module cable_phy_model (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Set by the bench
    input  wire  [7:0]  delay,
    input  wire  [11:0] result,
    // Bank handshake
    input  wire         cable_test_start,
    output logic        cable_test_done,
    output logic [11:0] res_out
);
    logic [7:0] cnt_q;
    // Result lines hold garbage outside the done pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
            cable_test_done <= 1'b0;
            res_out <= 12'hFFF;
        end else begin
            cable_test_done <= 1'b0;
            res_out <= ~result;
            if (cable_test_start && !cable_test_done) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q >= delay) begin
                    cable_test_done <= 1'b1;
                    res_out <= result;
                    cnt_q <= 8'h00;
                end
            end
        end
    end
endmodule

// file: sim/test_port_phy_control_status_regs.sv
/* Self-checking bench for the port PHY register bank.
   Assumes one AHB-Lite slave whose hreadyout is the bus hready. */
`timescale 1ns/10ps
`include "port_phy_map.vh"
module test_port_phy_control_status_regs;
    localparam logic [31:0] A_DIAG = `IDX_CABLE_DIAG_SPECIAL_CTRL * 4;
    localparam logic [31:0] A_CTRL = `IDX_PORT_PHY_CONTROL * 4;
    localparam logic [31:0] A_STAT = `IDX_PORT_PHY_STATUS * 4;
    logic        hclk, hresetn, hsel, hwrite, pol, txfc, rxfc, s15;
    logic [31:0] haddr, hwdata, d, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] res;
    logic [7:0]  dly;
    logic [15:0] dm, cm;
    logic [31:0] tbl [8];
    wire         hready, hreadyout, hresp, start, done, an_restart;
    wire  [31:0] hrdata;
    wire  [11:0] res_in;
    wire  [15:0] pins;
    integer      seed, num_errors, n_checks, i, k;
    assign hready = hreadyout;
    port_phy_control_status_regs i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cable_test_start(start), .cable_test_done(done),
        .near_short_in(res_in[11]), .cable_test_outcome_in(res_in[10:9]),
        .fault_distance_in(res_in[8:0]), .polarity_reversed(pol),
        .tx_flow_ctrl_active(txfc), .rx_flow_ctrl_active(rxfc),
        .force_link_pass(pins[2]), .near_loopback(pins[1]),
        .tx_disable(pins[15]), .an_restart(an_restart),
        .power_down(pins[14]), .auto_mdix_disable(pins[13]),
        .force_mdix(pins[12]), .far_loopback(pins[11]),
        .an_enable(pins[10]), .force_speed_100(pins[9]),
        .force_full_duplex(pins[8]), .advertise(pins[7:3]),
        .crossover_algorithm_select(pins[0]));
    cable_phy_model i_phy (
        .hclk(hclk), .hresetn(hresetn), .delay(dly), .result(res),
        .cable_test_start(start), .cable_test_done(done), .res_out(res_in));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic note_err(input string msg);
        $display("CHECK FAILED %0t %s", $time, msg);
        num_errors++;
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) note_err("read data");
    endtask
    task automatic chk_pin(input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) note_err("control outputs");
    endtask
    task automatic wait_rdy;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            note_err("bus hang");
            complete_run;
        end
    endtask
    // Called just after an edge, so transfers run back to back
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd_v);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd_v = hrdata;
    endtask
    function automatic logic [31:0] exp_rd(input logic [31:0] a);
        case (a)
            A_DIAG: exp_rd = {16'h0000, dm};
            A_CTRL: exp_rd = {16'h0000, cm};
            A_STAT: exp_rd = {16'h0000, s15, 1'b0, pol, txfc, rxfc, 11'h0};
            `ADDR_PHY_BASIC_CONTROL: exp_rd = {17'h0, cm[8], cm[6], cm[7],
                cm[11], 2'b0, cm[5], 2'b0, s15, cm[9], cm[10], cm[12],
                cm[14], 1'b0};
            `ADDR_PHY_ADVERTISEMENT: exp_rd = {21'h0, cm[4], 1'b0,
                cm[3:0], 5'h0};
            `ADDR_PHY_SPECIAL_CONTROL: exp_rd = {26'h0, pol, 1'b0,
                dm[11], 1'b0, dm[9], 1'b0};
            default: exp_rd = 32'h0;
        endcase
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        bus(a, 1'b1, v, r);
        case (a)
            A_DIAG: dm[12:9] = {dm[12] | v[12], v[11:9]};
            A_CTRL: cm = v[15:0] & 16'hDFFF;
            A_STAT: s15 = v[15];
            `ADDR_PHY_BASIC_CONTROL: begin
                {cm[14], cm[12:5]} = {v[1], v[2], v[11], v[3], v[4],
                                      v[14], v[12], v[13], v[8]};
                s15 = v[5];
            end
            `ADDR_PHY_ADVERTISEMENT: cm[4:0] = {v[10], v[8:5]};
            `ADDR_PHY_SPECIAL_CONTROL: {dm[11], dm[9]} = {v[3], v[1]};
            default: ;
        endcase
    endtask
    task automatic rd(input logic [31:0] a);
        bus(a, 1'b0, 32'h0, r);
        chk_rd(exp_rd(a), r);
        chk_pin({cm[14], cm[11:0], dm[11], dm[9], s15}, pins);
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        seed = 32'h0fe675f6;
        num_errors = 0;
        n_checks = 0;
        {hresetn, hsel, hwrite, pol, txfc, rxfc, htrans} = 8'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        dly = 8'h00;
        res = 12'h000;
        {dm, cm, s15} = {16'h0400, 16'h00FF, 1'b1};
        tbl = '{A_CTRL, A_DIAG, A_STAT, `ADDR_PHY_BASIC_CONTROL,
                `ADDR_PHY_ADVERTISEMENT, `ADDR_PHY_SPECIAL_CONTROL,
                32'h0204, 32'h11F8};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(A_DIAG);
        rd(A_CTRL);
        rd(A_STAT);
        $display("test reset values done");
        for (i = 0; i < 32; i++) begin
            d = $random(seed);
            if (tbl[i % 8] == A_DIAG) d[12] = 1'b0;
            // Duplex bit kept zero while negotiation is on
            if (tbl[i % 8] == A_CTRL && d[7])
                d[5] = 1'b0;
            if (tbl[i % 8] == `ADDR_PHY_BASIC_CONTROL && d[12])
                d[8] = 1'b0;
            {pol, txfc, rxfc} <= d[31:29];
            wr(tbl[i % 8], d);
            rd(A_CTRL);
            rd(A_DIAG);
            rd(A_STAT);
            rd(tbl[(i + 3) % 8]);
        end
        rd(32'h11F8);
        $display("test register writes done");
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            res <= {d[11], i[1:0], d[8:0]};
            dly <= i[2] ? 8'h28 : 8'h00;
            wr(A_DIAG, {16'h0000, dm} | 32'h1000);
            k = 0;
            do begin
                bus(A_DIAG, 1'b0, 32'h0, r);
                k++;
            end while (r[12] !== 1'b0 && k < 40);
            if (r[12] !== 1'b0) begin
                note_err("cable test hang");
                complete_run;
            end
            dm = {res[11:9], 1'b0, dm[11:9], res[8:0]};
            chk_rd(exp_rd(A_DIAG), r);
        end
        $display("test cable diagnostics done");
        complete_run;
    end
endmodule
bind port_phy_control_status_regs port_phy_regs_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cable_test_start(cable_test_start), .cable_test_done(cable_test_done),
    .an_restart(an_restart), .tx_disable(tx_disable),
    .power_down(power_down));
